// ### verification/testbench.sv
// Self-checking bench of the limit and alarm block
`timescale 1ns/10ps
module testbench;
    typedef struct packed {logic [7:0] lt, rt, off, lo, hi, fs; logic op, ea, ef;} tlas_row_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, alert_reply_address = 1'b0, open_detect = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, lval = 8'h19, rval = 8'h19, reg_rdata, adc_result;
    logic adc_start, adc_remote_sel, adc_abort, adc_done, adc_under_range;
    logic alert_n_out, alert_n_oe, fs_n_out, fs_n_oe;
    int miscompares = 0, checked = 0, cyc = 0, starts = 0, i;
    // Host keeps each fail-safe limit at or above the high limit
    tlas_row_s rows [9] = '{
        '{8'h19, 8'h19, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b0, 1'b0},
        '{8'h00, 8'h19, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b1, 1'b0},
        '{8'h19, 8'h32, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b0, 1'b0},
        '{8'h19, 8'h33, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b1, 1'b0},
        '{8'h3d, 8'h19, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b1, 1'b1},
        '{8'h19, 8'h3d, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b1, 1'b1},
        '{8'h19, 8'h34, 8'hff, 8'h00, 8'h32, 8'h3c, 1'b0, 1'b1, 1'b0},
        '{8'h19, 8'h80, 8'h00, 8'h80, 8'h32, 8'h3c, 1'b0, 1'b1, 1'b0},
        '{8'h19, 8'h19, 8'h00, 8'h00, 8'h32, 8'h3c, 1'b1, 1'b1, 1'b0}};
    tlas_top #(.GAP_CYCLES(4)) i_tlas_top (.clock(clock), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .alert_reply_address(alert_reply_address), .adc_start(adc_start), .adc_remote_sel(adc_remote_sel),
        .adc_abort(adc_abort), .adc_done(adc_done), .adc_result(adc_result), .adc_under_range(adc_under_range),
        .open_detect(open_detect), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .failsafe_overtemp_n_out(fs_n_out), .failsafe_overtemp_n_oe(fs_n_oe));
    tlas_adc_model i_tlas_adc_model (.clock(clock), .rst_n(rst_n), .adc_start(adc_start),
        .adc_remote_sel(adc_remote_sel), .adc_abort(adc_abort), .local_val(lval), .remote_val(rval),
        .adc_done(adc_done), .adc_result(adc_result), .adc_under_range(adc_under_range));
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Hang guard at 8000 cycles, well above the roughly 1230 cycles the tests need; counts starts too
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (adc_start === 1'b1) starts = starts + 1;
        if (cyc == 8000) begin
            miscompares = miscompares + 1;
            finish_test;
        end
    end
    task automatic finish_test;
        $display("Counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr_en <= 1'b0;
    endtask
    // Read data is settled one step after the taking edge
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic do_reset;
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    // Let n full rounds land, then answer the alert address once
    task automatic settle(input int n);
        repeat (n) @(posedge clock iff (adc_done === 1'b1 && adc_remote_sel === 1'b1));
        repeat (4) @(posedge clock);
        alert_reply_address <= 1'b1;
        @(posedge clock);
        alert_reply_address <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic step(input logic [7:0] l, input logic [7:0] r, input logic e);
        lval <= l;
        rval <= r;
        settle(2);
        chk({7'h00, fs_n_oe}, {7'h00, e});
    endtask
    // Row table first, then hysteresis, registers, standby and masking
    initial begin
        for (i = 0; i < 9; i++) begin
            do_reset;
            lval <= rows[i].lt;
            rval <= rows[i].rt;
            open_detect <= rows[i].op;
            wr(tlas_pkg::ADDR_REMOTE_OFFSET, rows[i].off);
            wr(tlas_pkg::ADDR_LOCAL_LOW, rows[i].lo);
            wr(tlas_pkg::ADDR_REMOTE_LOW, rows[i].lo);
            wr(tlas_pkg::ADDR_LOCAL_HIGH, rows[i].hi);
            wr(tlas_pkg::ADDR_REMOTE_HIGH, rows[i].hi);
            wr(tlas_pkg::ADDR_LOCAL_FAILSAFE, rows[i].fs);
            wr(tlas_pkg::ADDR_REMOTE_FAILSAFE, rows[i].fs);
            settle(2);
            chk({7'h00, alert_n_oe}, {7'h00, rows[i].ea});
            chk({7'h00, fs_n_oe}, {7'h00, rows[i].ef});
            rdc(tlas_pkg::ADDR_REMOTE_TEMP, rows[i].rt + rows[i].off);
            $display("Row %0d done", i);
        end
        rdc(tlas_pkg::ADDR_STATUS, 8'h84);
        open_detect <= 1'b0;
        do_reset;
        wr(tlas_pkg::ADDR_LOCAL_FAILSAFE, 8'h3c);
        wr(tlas_pkg::ADDR_REMOTE_FAILSAFE, 8'h3c);
        wr(tlas_pkg::ADDR_LOCAL_HIGH, 8'h32);
        wr(tlas_pkg::ADDR_REMOTE_HIGH, 8'h32);
        step(8'h3d, 8'h19, 1'b1);
        step(8'h33, 8'h19, 1'b1);
        step(8'h31, 8'h3d, 1'b1);
        step(8'h31, 8'h33, 1'b1);
        step(8'h31, 8'h31, 1'b0);
        rdc(tlas_pkg::ADDR_FAILSAFE_HYST, 8'h0a);
        rdc(tlas_pkg::ADDR_LOCAL_LOW, 8'h00);
        wr(tlas_pkg::ADDR_FAILSAFE_HYST, 8'h01);
        rdc(tlas_pkg::ADDR_FAILSAFE_HYST, 8'h01);
        rdc(8'h0c, 8'h00);
        $display("Hysteresis and register test done");
        // Standby lands while a slow remote conversion runs
        do_reset;
        settle(1);
        @(posedge clock iff adc_start === 1'b1);
        lval <= 8'h05;
        rval <= 8'h05;
        wr(tlas_pkg::ADDR_CONFIG, 8'h40);
        repeat (4) @(posedge clock);
        #1 starts = 0;
        repeat (40) @(posedge clock);
        chk(8'(starts), 8'h00);
        rdc(tlas_pkg::ADDR_REMOTE_TEMP, 8'h31);
        wr(tlas_pkg::ADDR_LOCAL_LOW, 8'h40);
        repeat (4) @(posedge clock);
        chk({7'h00, alert_n_oe}, 8'h01);
        wr(tlas_pkg::ADDR_SINGLE_CONV, 8'ha5);
        #1 starts = 0;
        repeat (60) @(posedge clock);
        chk(8'(starts), 8'h02);
        rdc(tlas_pkg::ADDR_LOCAL_TEMP, 8'h05);
        rdc(tlas_pkg::ADDR_SINGLE_CONV, 8'h00);
        $display("Standby test done");
        do_reset;
        wr(tlas_pkg::ADDR_CONFIG, 8'h80);
        wr(tlas_pkg::ADDR_LOCAL_HIGH, 8'h32);
        wr(tlas_pkg::ADDR_LOCAL_FAILSAFE, 8'h3c);
        step(8'h3d, 8'h19, 1'b1);
        chk({7'h00, alert_n_oe}, 8'h00);
        $display("Mask test done");
        finish_test;
    end
endmodule

// ### verification/tlas_adc_model.sv
// Behavioural converter answering the block's conversion requests
`timescale 1ns/10ps
module tlas_adc_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Requests from the block
    input wire logic adc_start,
    input wire logic adc_remote_sel,
    input wire logic adc_abort,
    // Readings to report; remote 0x80 stands for a shorted diode
    input wire logic [7:0] local_val,
    input wire logic [7:0] remote_val,
    // Answers
    output logic adc_done,
    output logic [7:0] adc_result,
    output logic adc_under_range
);
    logic busy_r;
    logic sel_r;
    logic [4:0] cnt_r;
    logic [7:0] last_r;
    logic [7:0] val;
    logic under;
    // Reading and fault flag of the channel in conversion
    assign val = sel_r ? remote_val : local_val;
    assign under = sel_r && remote_val == 8'h80;
    // Odd readings convert slowly, even ones promptly; result bus never holds stale data
    always_ff @(posedge clock) begin
        adc_done <= 1'b0;
        adc_under_range <= 1'b0;
        adc_result <= ~last_r;
        if (!rst_n || adc_abort) begin
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
            last_r <= 8'h00;
        end else if (adc_start) begin
            busy_r <= 1'b1;
            sel_r <= adc_remote_sel;
            cnt_r <= (adc_remote_sel ? remote_val[0] : local_val[0]) ? 5'h0a : 5'h02;
        end else if (busy_r && cnt_r > 5'h01) begin
            cnt_r <= cnt_r - 5'h01;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            adc_done <= 1'b1;
            adc_result <= val;
            adc_under_range <= under;
            last_r <= val;
        end
    end
endmodule

// ### verification/tlas_assertions.sv
// Port-level checks of the limit and alarm block
`timescale 1ns/10ps
module tlas_assertions #(
    parameter int GAP_CYCLES = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register access
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic alert_reply_address,
    // Converter side
    input wire logic adc_start,
    input wire logic adc_remote_sel,
    input wire logic adc_abort,
    input wire logic adc_done,
    // Alarm pins
    input wire logic alert_n_out,
    input wire logic alert_n_oe,
    input wire logic failsafe_overtemp_n_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A standby write at the result edge is excluded: the outcome there is open
    sequence s_local_done; adc_done && !adc_remote_sel && !adc_abort && !reg_wr_en; endsequence
    sequence s_remote_start; adc_start && adc_remote_sel; endsequence
    property p_remote_after_local; s_local_done |=> s_remote_start; endproperty
    a_remote_after_local: assert property (p_remote_after_local) else $error("no remote start after local");
    property p_start_pulse; adc_start |=> !adc_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
    property p_abort_quiet; adc_abort |-> !adc_start ##1 !adc_start; endproperty
    a_abort_quiet: assert property (p_abort_quiet) else $error("start right after abort");
    property p_sel_steady; adc_done |-> $stable(adc_remote_sel); endproperty
    a_sel_steady: assert property (p_sel_steady) else $error("channel changed mid conversion");
    // Bench runs with a gap of four, so two quiet cycles are always owed
    property p_gap; adc_done && adc_remote_sel |=> !adc_start [*2]; endproperty
    a_gap: assert property (p_gap) else $error("no idle gap after remote result");
    property p_pins_low; alert_n_out == 1'b0 && failsafe_overtemp_n_out == 1'b0; endproperty
    a_pins_low: assert property (p_pins_low) else $error("open drain data not low");
    property p_alert_latched;
        alert_n_oe && !alert_reply_address && !$past(alert_reply_address) |=> alert_n_oe;
    endproperty
    a_alert_latched: assert property (p_alert_latched) else $error("alert dropped without reply");
    property p_single_read_zero; reg_rd_en && reg_addr == tlas_pkg::ADDR_SINGLE_CONV |=> reg_rdata == 8'h00;
    endproperty
    a_single_read_zero: assert property (p_single_read_zero) else $error("trigger data was stored");
    property p_rdata_stands; !reg_rd_en |=> $stable(reg_rdata); endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data changed unasked");
endmodule

bind tlas_top tlas_assertions #(.GAP_CYCLES(GAP_CYCLES)) u_tlas_assertions (.clock(clock), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .alert_reply_address(alert_reply_address), .adc_start(adc_start), .adc_remote_sel(adc_remote_sel),
    .adc_abort(adc_abort), .adc_done(adc_done), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .failsafe_overtemp_n_out(failsafe_overtemp_n_out));

// ### verilog/tlas_pkg.sv
// Constants, register map and state codes of the temperature limit and alarm block
//
// Notes on behaviour
// [RULE1] Config bit 6 high selects standby; low runs continuous conversions.
// [RULE2] Entering standby aborts a running conversion and discards its result.
// [RULE3] Register reads and writes keep working while in standby.
// [RULE4] Any write to 0x0f converts both channels once, then standby resumes.
// [RULE5] Limit writes in standby re-check stored values and may raise alert.
// [RULE6] Alert is maskable; the over-temperature output can never be masked.
// [RULE7] Alert when a temperature is equal to or below its low limit.
// [RULE8] No alert while all temperatures lie between low and high limits.
// [RULE9] Alert when local or remote temperature is strictly above its high limit.
// [RULE10] Separate local and remote fail-safe limits drive over-temperature low.
// [RULE11] Host should set each fail-safe limit at or above its high limit.
// [RULE12] Hysteresis resets to 10 degrees and takes any later written value.
// [RULE13] One hysteresis value serves both over-temperature comparisons.
// [RULE14] Hysteresis is unsigned whole degrees, one degree per bit.
// [RULE15] Open-diode detector sampled at conversion start sets status bit 2.
// [RULE16] Under-range remote signal reports -128, code 0x80.
// [RULE17] Low test is less-or-equal, so -128 alerts even at minimum limit.
// [RULE18] Low limits reset to 0 degrees.
// [RULE19] Signed offset register is added to every remote measurement.
// [RULE20] Open remote sensor also pulls the alert output low.
// [RULE21] Alert releases after alert-address reply once its cause has gone.
// [RULE22] Data written to the single-shot register is ignored and not stored.
// [RULE23] Over-temperature releases below fail-safe limit minus hysteresis.
package tlas_pkg;

    // Register offsets (8-bit pointer space)
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h01;
    localparam logic [7:0] ADDR_REMOTE_TEMP = 8'h02;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h04;
    localparam logic [7:0] ADDR_LOCAL_LOW = 8'h05;
    localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h06;
    localparam logic [7:0] ADDR_REMOTE_LOW = 8'h07;
    localparam logic [7:0] ADDR_REMOTE_OFFSET = 8'h08;
    localparam logic [7:0] ADDR_LOCAL_FAILSAFE = 8'h09;
    localparam logic [7:0] ADDR_REMOTE_FAILSAFE = 8'h0a;
    localparam logic [7:0] ADDR_FAILSAFE_HYST = 8'h0b;
    localparam logic [7:0] ADDR_SINGLE_CONV = 8'h0f;

    // Config fields
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_ALERT_MASK_BIT = 7;

    // Status fields
    localparam int ST_LOCAL_FS_BIT = 0;
    localparam int ST_REMOTE_FS_BIT = 1;
    localparam int ST_OPEN_BIT = 2;
    localparam int ST_REMOTE_LOW_BIT = 3;
    localparam int ST_REMOTE_HIGH_BIT = 4;
    localparam int ST_LOCAL_LOW_BIT = 5;
    localparam int ST_LOCAL_HIGH_BIT = 6;
    localparam int ST_BUSY_BIT = 7;

    // Reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_HIGH = 8'h7f;
    localparam logic [7:0] RST_LOW = 8'h00;
    localparam logic [7:0] RST_FAILSAFE = 8'h7f;
    localparam logic [7:0] RST_HYST = 8'h0a;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] UNDER_RANGE_CODE = 8'h80;

    // Default idle gap between conversion rounds, in clock cycles
    localparam int CONV_GAP_CYCLES = 16;

    // Conversion sequencer, one-hot
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_LOCAL = 4'b0010,
        SEQ_REMOTE = 4'b0100,
        SEQ_GAP = 4'b1000
    } tlas_seq_e;

endpackage

// ### verilog/tlas_top.sv
// Limit checking, alarm outputs, standby and single-shot control of the monitor
`timescale 1ns/10ps
module tlas_top #(
    parameter int GAP_CYCLES = tlas_pkg::CONV_GAP_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Decoded register access from the serial slave
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Alert reply address answered by the serial slave
    input wire logic alert_reply_address,
    // Converter interface
    output logic adc_start,
    output logic adc_remote_sel,
    output logic adc_abort,
    input wire logic adc_done,
    input wire logic [7:0] adc_result,
    input wire logic adc_under_range,
    input wire logic open_detect,
    // Open-drain alarm pins
    output logic alert_n_out,
    output logic alert_n_oe,
    output logic failsafe_overtemp_n_out,
    output logic failsafe_overtemp_n_oe
);

    localparam logic [15:0] GAP_LAST = 16'(GAP_CYCLES - 1);

    tlas_pkg::tlas_seq_e seq_r;
    tlas_pkg::tlas_seq_e seq_nxt;
    logic [15:0] gap_cnt_r;
    logic single_pend_r;
    logic [7:0] config_r;
    logic [7:0] local_temp_r;
    logic [7:0] remote_temp_r;
    logic [7:0] local_high_r;
    logic [7:0] local_low_r;
    logic [7:0] remote_high_r;
    logic [7:0] remote_low_r;
    logic [7:0] offset_r;
    logic [7:0] local_fs_r;
    logic [7:0] remote_fs_r;
    logic [7:0] hyst_r;
    logic open_fault_r;
    logic local_fs_hit_r;
    logic remote_fs_hit_r;
    logic alert_hold_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic start_r;
    logic sel_r;
    logic abort_r;
    logic alert_oe_r;
    logic fs_oe_r;
    logic pin_low_r;

    // Write strobes
    wire wr_config = reg_wr_en && (reg_addr == tlas_pkg::ADDR_CONFIG);
    wire wr_local_high = reg_wr_en && (reg_addr == tlas_pkg::ADDR_LOCAL_HIGH);
    wire wr_local_low = reg_wr_en && (reg_addr == tlas_pkg::ADDR_LOCAL_LOW);
    wire wr_remote_high = reg_wr_en && (reg_addr == tlas_pkg::ADDR_REMOTE_HIGH);
    wire wr_remote_low = reg_wr_en && (reg_addr == tlas_pkg::ADDR_REMOTE_LOW);
    wire wr_offset = reg_wr_en && (reg_addr == tlas_pkg::ADDR_REMOTE_OFFSET);
    wire wr_local_fs = reg_wr_en && (reg_addr == tlas_pkg::ADDR_LOCAL_FAILSAFE);
    wire wr_remote_fs = reg_wr_en && (reg_addr == tlas_pkg::ADDR_REMOTE_FAILSAFE);
    wire wr_hyst = reg_wr_en && (reg_addr == tlas_pkg::ADDR_FAILSAFE_HYST);
    wire wr_single = reg_wr_en && (reg_addr == tlas_pkg::ADDR_SINGLE_CONV); // RULE22

    // Mode and sequencing terms
    wire standby = config_r[tlas_pkg::CFG_STANDBY_BIT]; // RULE1
    wire alert_mask = config_r[tlas_pkg::CFG_ALERT_MASK_BIT];
    wire converting = (seq_r == tlas_pkg::SEQ_LOCAL) || (seq_r == tlas_pkg::SEQ_REMOTE);
    wire kill_conv = converting && standby && !single_pend_r; // RULE2
    wire local_done = (seq_r == tlas_pkg::SEQ_LOCAL) && adc_done && !kill_conv;
    wire remote_done = (seq_r == tlas_pkg::SEQ_REMOTE) && adc_done && !kill_conv;

    // Remote value: signed offset added with saturation, under-range forced to -128
    wire signed [8:0] remote_sum = $signed({adc_result[7], adc_result}) + $signed({offset_r[7], offset_r}); // RULE19
    wire sum_high = !remote_sum[8] && remote_sum[7];
    wire sum_low = remote_sum[8] && !remote_sum[7];
    wire [7:0] remote_sat = sum_high ? 8'h7f : (sum_low ? 8'h80 : remote_sum[7:0]);
    wire [7:0] remote_value = adc_under_range ? tlas_pkg::UNDER_RANGE_CODE : remote_sat; // RULE16

    // Limit comparisons on stored values, live so limit writes re-check at once
    wire local_low_hit = $signed(local_temp_r) <= $signed(local_low_r); // RULE7 RULE17
    wire remote_low_hit = $signed(remote_temp_r) <= $signed(remote_low_r); // RULE7 RULE17
    wire local_high_hit = $signed(local_temp_r) > $signed(local_high_r); // RULE9
    wire remote_high_hit = $signed(remote_temp_r) > $signed(remote_high_r); // RULE9
    wire alert_cause = local_low_hit || remote_low_hit || local_high_hit || remote_high_hit
        || open_fault_r; // RULE5 RULE8 RULE20

    // Fail-safe set above limit, release below limit minus shared hysteresis
    wire signed [9:0] local_release = $signed({{2{local_fs_r[7]}}, local_fs_r})
        - $signed({2'b00, hyst_r}); // RULE13 RULE14
    wire signed [9:0] remote_release = $signed({{2{remote_fs_r[7]}}, remote_fs_r})
        - $signed({2'b00, hyst_r}); // RULE13 RULE14
    wire local_fs_set = $signed(local_temp_r) > $signed(local_fs_r); // RULE10
    wire remote_fs_set = $signed(remote_temp_r) > $signed(remote_fs_r); // RULE10
    wire local_fs_clr = $signed({{2{local_temp_r[7]}}, local_temp_r}) < local_release; // RULE23
    wire remote_fs_clr = $signed({{2{remote_temp_r[7]}}, remote_temp_r}) < remote_release; // RULE23

    wire [7:0] status = {converting, local_high_hit, local_low_hit, remote_high_hit, remote_low_hit,
        open_fault_r, remote_fs_hit_r, local_fs_hit_r};

    // Sequencer next state
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            tlas_pkg::SEQ_IDLE: begin
                if (!standby || single_pend_r) begin
                    seq_nxt = tlas_pkg::SEQ_LOCAL;
                end
            end
            tlas_pkg::SEQ_LOCAL: begin
                if (kill_conv) begin
                    seq_nxt = tlas_pkg::SEQ_IDLE;
                end else if (adc_done) begin
                    seq_nxt = tlas_pkg::SEQ_REMOTE;
                end
            end
            tlas_pkg::SEQ_REMOTE: begin
                if (kill_conv) begin
                    seq_nxt = tlas_pkg::SEQ_IDLE;
                end else if (adc_done) begin
                    seq_nxt = single_pend_r ? tlas_pkg::SEQ_IDLE : tlas_pkg::SEQ_GAP; // RULE4
                end
            end
            tlas_pkg::SEQ_GAP: begin
                if (standby) begin
                    seq_nxt = tlas_pkg::SEQ_IDLE;
                end else if (gap_cnt_r == GAP_LAST) begin
                    seq_nxt = tlas_pkg::SEQ_LOCAL;
                end
            end
            default: seq_nxt = tlas_pkg::SEQ_IDLE;
        endcase
    end

    // Sequencer state and gap counter
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seq_r <= tlas_pkg::SEQ_IDLE;
            gap_cnt_r <= 16'h0000;
        end else begin
            seq_r <= seq_nxt;
            gap_cnt_r <= (seq_r == tlas_pkg::SEQ_GAP) ? gap_cnt_r + 16'h0001 : 16'h0000;
        end
    end

    // Single-shot request: only meaningful in standby; ends after the remote result
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            single_pend_r <= 1'b0;
        end else if (wr_single && standby && !single_pend_r) begin
            single_pend_r <= 1'b1; // RULE4
        end else if (remote_done || !standby) begin
            single_pend_r <= 1'b0;
        end
    end

    // Converter handshake pulses
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_r <= 1'b0;
            sel_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            start_r <= (seq_nxt != seq_r) && ((seq_nxt == tlas_pkg::SEQ_LOCAL) || (seq_nxt == tlas_pkg::SEQ_REMOTE));
            sel_r <= (seq_nxt == tlas_pkg::SEQ_REMOTE);
            abort_r <= kill_conv; // RULE2
        end
    end

    // Open detector caught at the start of each remote conversion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            open_fault_r <= 1'b0;
        end else if ((seq_nxt == tlas_pkg::SEQ_REMOTE) && (seq_r != tlas_pkg::SEQ_REMOTE)) begin
            open_fault_r <= open_detect; // RULE15
        end
    end

    // Temperature values; an aborted conversion never lands here
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            local_temp_r <= tlas_pkg::RST_TEMP;
            remote_temp_r <= tlas_pkg::RST_TEMP;
        end else begin
            if (local_done) begin
                local_temp_r <= adc_result; // RULE2
            end
            if (remote_done) begin
                remote_temp_r <= remote_value; // RULE2 RULE19
            end
        end
    end

    // Software registers, writable in any mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            config_r <= tlas_pkg::RST_CONFIG;
            local_high_r <= tlas_pkg::RST_HIGH;
            local_low_r <= tlas_pkg::RST_LOW; // RULE18
            remote_high_r <= tlas_pkg::RST_HIGH;
            remote_low_r <= tlas_pkg::RST_LOW; // RULE18
            offset_r <= tlas_pkg::RST_OFFSET;
            local_fs_r <= tlas_pkg::RST_FAILSAFE;
            remote_fs_r <= tlas_pkg::RST_FAILSAFE;
            hyst_r <= tlas_pkg::RST_HYST; // RULE12
        end else begin
            if (wr_config) config_r <= reg_wdata; // RULE3
            if (wr_local_high) local_high_r <= reg_wdata; // RULE5
            if (wr_local_low) local_low_r <= reg_wdata; // RULE5
            if (wr_remote_high) remote_high_r <= reg_wdata; // RULE5
            if (wr_remote_low) remote_low_r <= reg_wdata; // RULE5
            if (wr_offset) offset_r <= reg_wdata;
            if (wr_local_fs) local_fs_r <= reg_wdata;
            if (wr_remote_fs) remote_fs_r <= reg_wdata;
            if (wr_hyst) hyst_r <= reg_wdata; // RULE12
        end
    end

    // Read mux; the single-shot address is write-only and reads zero
    always_comb begin
        if (reg_addr == tlas_pkg::ADDR_CONFIG) begin
            rdata_nxt = config_r;
        end else if (reg_addr == tlas_pkg::ADDR_LOCAL_TEMP) begin
            rdata_nxt = local_temp_r;
        end else if (reg_addr == tlas_pkg::ADDR_REMOTE_TEMP) begin
            rdata_nxt = remote_temp_r;
        end else if (reg_addr == tlas_pkg::ADDR_STATUS) begin
            rdata_nxt = status; // RULE15
        end else if (reg_addr == tlas_pkg::ADDR_LOCAL_HIGH) begin
            rdata_nxt = local_high_r;
        end else if (reg_addr == tlas_pkg::ADDR_LOCAL_LOW) begin
            rdata_nxt = local_low_r;
        end else if (reg_addr == tlas_pkg::ADDR_REMOTE_HIGH) begin
            rdata_nxt = remote_high_r;
        end else if (reg_addr == tlas_pkg::ADDR_REMOTE_LOW) begin
            rdata_nxt = remote_low_r;
        end else if (reg_addr == tlas_pkg::ADDR_REMOTE_OFFSET) begin
            rdata_nxt = offset_r;
        end else if (reg_addr == tlas_pkg::ADDR_LOCAL_FAILSAFE) begin
            rdata_nxt = local_fs_r;
        end else if (reg_addr == tlas_pkg::ADDR_REMOTE_FAILSAFE) begin
            rdata_nxt = remote_fs_r;
        end else if (reg_addr == tlas_pkg::ADDR_FAILSAFE_HYST) begin
            rdata_nxt = hyst_r;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // Read data held until the next read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_r <= rdata_nxt; // RULE3
        end
    end

    // Alert latch: a live cause wins over the reply-address release unless config bit 7 masks alert
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            alert_hold_r <= 1'b0;
        end else if (alert_cause && !alert_mask) begin
            alert_hold_r <= 1'b1; // RULE6 RULE7 RULE9
        end else if (alert_reply_address) begin
            alert_hold_r <= 1'b0; // RULE21
        end
    end

    // Fail-safe hysteresis flags, no mask term anywhere on this path
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            local_fs_hit_r <= 1'b0;
            remote_fs_hit_r <= 1'b0;
        end else begin
            if (local_fs_set) local_fs_hit_r <= 1'b1; // RULE10
            else if (local_fs_clr) local_fs_hit_r <= 1'b0; // RULE23
            if (remote_fs_set) remote_fs_hit_r <= 1'b1; // RULE10
            else if (remote_fs_clr) remote_fs_hit_r <= 1'b0; // RULE23
        end
    end

    // Pin drivers: open drain, so the data level is always low and only enables move
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            alert_oe_r <= 1'b0;
            fs_oe_r <= 1'b0;
            pin_low_r <= 1'b0;
        end else begin
            alert_oe_r <= alert_hold_r; // RULE6
            fs_oe_r <= local_fs_hit_r || remote_fs_hit_r; // RULE6 RULE10
            pin_low_r <= 1'b0;
        end
    end

    assign reg_rdata = rdata_r;
    assign adc_start = start_r;
    assign adc_remote_sel = sel_r;
    assign adc_abort = abort_r;
    assign alert_n_out = pin_low_r;
    assign alert_n_oe = alert_oe_r;
    assign failsafe_overtemp_n_out = pin_low_r;
    assign failsafe_overtemp_n_oe = fs_oe_r;

endmodule
